/* hw/inf_monitor.sv */
// Input format monitor: sync timing, format change, watchdog, field and pixel stats.
// Assumes sync pins and pixel data are synchronous to core_clk.
//
// Contract
// - Own unit reset bit disables measurement.
// - Runs regardless of chip power-down state.
// - Horizontal counts use selected measurement clock.
// - Internal syncs default to pin syncs.
// - Horizontal sync delayed by programmed input clocks.
// - Sync delay only on converter input path.
// - Vertical sync clears, horizontal sync advances lines.
// - Measure horizontal period and high pulse width.
// - Horizontal measure on one programmed line.
// - Vertical period and width in line edges.
// - Measure between rising vertical syncs, repeating.
// - Threshold compare to previous sets change bits.
// - Horizontal period watchdog sets status bit.
// - Vertical period watchdog sets separate bit.
// - Odd field when vertical edge in window; code flags it only on the converter path, else holds even.
// - Option swaps odd and even fields.
// - Window points chosen from fixed table.
// - Phase quality summed over active window.
// - Image boundary measured for centring.
// - Pixel minimum and maximum for balance.
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module inf_monitor
    import inf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic hsync_pin,
    input wire logic vsync_pin,
    input wire logic adc_path,
    input wire logic xtal_tick,
    input wire logic synth_tick,
    input wire logic pix_en,
    input wire logic [PIX_W-1:0] pix_data,
    output logic field_odd,
    output logic unit_active
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [DATA_W-1:0] ctrl, hdly, mline, chg_thr, wd_thr, fwin, act_h, act_v;
    logic [ST_N-1:0] status, st_set, st_clr;
    logic act, meas_en, hs_int, vs_int, hs_q, vs_q;
    logic hs_rise, hs_fall, vs_rise, vs_fall, commit, armed, have_res;
    logic [CW-1:0] line_cnt, hcnt, vw_cnt, px;
    logic [CW-1:0] cur_h_per, cur_h_wid, cur_v_wid, fld_s, fld_e;
    inf_timing_t res;
    logic [PIX_W-1:0] prev_pix, pdiff, bal_min, bal_max, r_bal_min, r_bal_max;
    logic [DATA_W-1:0] phase_acc, r_phase;
    logic [CW-1:0] bx_min, bx_max, by_min, by_max;
    logic [CW-1:0] r_bx_min, r_bx_max, r_by_min, r_by_max;
    logic in_win, bright;
    logic [DATA_W-1:0] next_rdata;

    // The power-down state of the rest of the chip is not an input: the
    // unit is gated only by its own run and reset bits.
    assign act = ctrl[CTRL_RUN] & ~ctrl[CTRL_URST];
    assign unit_active = act;

    // ----------------------------------------
    // Sync front end
    // ----------------------------------------
    inf_clk_div u_div (
        .core_clk(core_clk),
        .rst(rst),
        .xtal_tick(xtal_tick),
        .synth_tick(synth_tick),
        .sel_synth(ctrl[CTRL_CSEL]),
        .meas_en(meas_en)
    );

    inf_hs_delay u_dly (
        .core_clk(core_clk),
        .rst(rst),
        .pix_en(pix_en),
        .hs_in(hsync_pin),
        .dly_on(ctrl[CTRL_DLY] & adc_path),
        .dly(hdly[DLY_W-1:0]),
        .hs_out(hs_int)
    );

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            vs_int <= 1'b0;
            hs_q <= 1'b0;
            vs_q <= 1'b0;
        end
        else
        begin
            vs_int <= vsync_pin;
            hs_q <= hs_int;
            vs_q <= vs_int;
        end
    end

    assign hs_rise = hs_int & ~hs_q;
    assign hs_fall = ~hs_int & hs_q;
    assign vs_rise = vs_int & ~vs_q;
    assign vs_fall = ~vs_int & vs_q;
    assign commit = act & vs_rise & armed;

    // ----------------------------------------
    // Counters
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            armed <= 1'b0;
        else if (!act)
            armed <= 1'b0;
        else if (vs_rise)
            armed <= 1'b1;
    end

    // A clear and an advance in one cycle leave the count at zero.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            line_cnt <= '0;
        else if (!act || vs_rise)
            line_cnt <= '0;
        else if (hs_rise)
            line_cnt <= line_cnt + 1'b1;
    end

    // Saturates so that a dead sync keeps the watchdog tripped every cycle.
    // The tick that meets the sync edge counts, so N ticks per line read as N.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            hcnt <= '0;
        else if (!act)
            hcnt <= '0;
        else if (hs_rise)
            hcnt <= CW'(meas_en);
        else if (meas_en && hcnt != '1)
            hcnt <= hcnt + 1'b1;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            vw_cnt <= '0;
        else if (!act || vs_rise)
            vw_cnt <= '0;
        else if (hs_rise && vs_int)
            vw_cnt <= vw_cnt + 1'b1;
    end

    // ----------------------------------------
    // Timing capture
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cur_h_per <= '0;
            cur_h_wid <= '0;
            cur_v_wid <= '0;
        end
        else if (act)
        begin
            if (hs_rise && line_cnt == mline[CW-1:0])
                cur_h_per <= hcnt;
            if (hs_fall && line_cnt == mline[CW-1:0])
                cur_h_wid <= hcnt;
            if (vs_fall)
                cur_v_wid <= vw_cnt;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            res <= '0;
            have_res <= 1'b0;
        end
        else if (commit)
        begin
            res <= '{h_per: cur_h_per, h_wid: cur_h_wid,
                     v_per: line_cnt, v_wid: cur_v_wid};
            have_res <= 1'b1;
        end
    end

    function automatic logic [CW-1:0] absd(input logic [CW-1:0] a, input logic [CW-1:0] b);
        absd = (a >= b) ? a - b : b - a;
    endfunction

    // ----------------------------------------
    // Status
    // ----------------------------------------
    always_comb
    begin
        st_set = '0;
        st_set[ST_HCHG] = commit && have_res &&
            absd(cur_h_per, res.h_per) > chg_thr[CW-1:0];
        st_set[ST_VCHG] = commit && have_res &&
            absd(line_cnt, res.v_per) > chg_thr[DATA_W-1:CW];
        st_set[ST_HWD] = act && hcnt > wd_thr[CW-1:0];
        st_set[ST_VWD] = act && line_cnt > wd_thr[DATA_W-1:CW];
        st_clr = (reg_wr && reg_addr == A_STAT) ? reg_wdata[ST_N-1:0] : '0;
    end

    // Write one to clear; a new event in the clearing cycle wins.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            status <= '0;
        else
            status <= (status & ~st_clr) | st_set;
    end

    // ----------------------------------------
    // Field detection
    // ----------------------------------------
    assign fld_s = FLD_PTS[fwin[FWIN_S +: FSEL_W]];
    assign fld_e = FLD_PTS[fwin[FWIN_E +: FSEL_W]];

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            field_odd <= 1'b0;
        else if (!act || !adc_path)
            field_odd <= 1'b0;
        else if (vs_rise)
            field_odd <= (hcnt >= fld_s && hcnt <= fld_e) ^ ctrl[CTRL_SWAP];
    end

    // ----------------------------------------
    // Pixel measurement
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            px <= '0;
        else if (!act || hs_rise)
            px <= '0;
        else if (pix_en && px != '1)
            px <= px + 1'b1;
    end

    assign in_win = pix_en && px >= act_h[CW-1:0] && px <= act_h[DATA_W-1:CW] &&
        line_cnt >= act_v[CW-1:0] && line_cnt <= act_v[DATA_W-1:CW];
    assign bright = pix_data > BND_LEVEL;
    assign pdiff = (pix_data >= prev_pix) ? pix_data - prev_pix : prev_pix - pix_data;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            prev_pix <= '0;
        else if (pix_en)
            prev_pix <= pix_data;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            phase_acc <= '0;
            bal_min <= '1;
            bal_max <= '0;
        end
        else if (!act || vs_rise)
        begin
            phase_acc <= '0;
            bal_min <= '1;
            bal_max <= '0;
        end
        else if (in_win)
        begin
            phase_acc <= phase_acc + DATA_W'(pdiff);
            if (pix_data < bal_min)
                bal_min <= pix_data;
            if (pix_data > bal_max)
                bal_max <= pix_data;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            bx_min <= '1;
            bx_max <= '0;
            by_min <= '1;
            by_max <= '0;
        end
        else if (!act || vs_rise)
        begin
            bx_min <= '1;
            bx_max <= '0;
            by_min <= '1;
            by_max <= '0;
        end
        else if (pix_en && bright)
        begin
            if (px < bx_min)
                bx_min <= px;
            if (px > bx_max)
                bx_max <= px;
            if (line_cnt < by_min)
                by_min <= line_cnt;
            if (line_cnt > by_max)
                by_max <= line_cnt;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            r_phase <= '0;
            r_bal_min <= '0;
            r_bal_max <= '0;
            r_bx_min <= '0;
            r_bx_max <= '0;
            r_by_min <= '0;
            r_by_max <= '0;
        end
        else if (commit)
        begin
            r_phase <= phase_acc;
            r_bal_min <= bal_min;
            r_bal_max <= bal_max;
            r_bx_min <= bx_min;
            r_bx_max <= bx_max;
            r_by_min <= by_min;
            r_by_max <= by_max;
        end
    end

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl <= CTRL_RST;
            hdly <= '0;
            mline <= MLINE_RST;
            chg_thr <= CHG_RST;
            wd_thr <= WDOG_RST;
            fwin <= FWIN_RST;
            act_h <= ACT_RST;
            act_v <= ACT_RST;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                A_CTRL: ctrl <= reg_wdata;
                A_HDLY: hdly <= reg_wdata;
                A_MLINE: mline <= reg_wdata;
                A_CHG: chg_thr <= reg_wdata;
                A_WDOG: wd_thr <= reg_wdata;
                A_FWIN: fwin <= reg_wdata;
                A_ACTH: act_h <= reg_wdata;
                A_ACTV: act_v <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_comb
    begin
        next_rdata = '0;
        unique case (reg_addr)
            A_CTRL: next_rdata = ctrl;
            A_HDLY: next_rdata = hdly;
            A_MLINE: next_rdata = mline;
            A_CHG: next_rdata = chg_thr;
            A_WDOG: next_rdata = wd_thr;
            A_FWIN: next_rdata = fwin;
            A_ACTH: next_rdata = act_h;
            A_ACTV: next_rdata = act_v;
            A_STAT:
            begin
                next_rdata[ST_N-1:0] = status;
                next_rdata[RD_ODD] = field_odd;
                next_rdata[RD_ARMED] = armed;
            end
            A_HRES: next_rdata = {res.h_wid, res.h_per};
            A_VRES: next_rdata = {res.v_wid, res.v_per};
            A_PHASE: next_rdata = r_phase;
            A_BNDH: next_rdata = {r_bx_max, r_bx_min};
            A_BNDV: next_rdata = {r_by_max, r_by_min};
            A_BAL: next_rdata = {{(DATA_W - 2 * PIX_W){1'b0}}, r_bal_max, r_bal_min};
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= '0;
        else
            reg_rdata <= reg_rd ? next_rdata : '0;
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_unit_off: assert property (!act |=> !armed && line_cnt == '0)
        else $error("unit reset did not stop measurement");
    chk_line_clear: assert property (act && vs_rise |=> line_cnt == '0)
        else $error("line counter not cleared by vertical sync");
    chk_line_step: assert property (act && hs_rise && !vs_rise
        |=> line_cnt == $past(line_cnt) + 1'b1)
        else $error("line counter not advanced by horizontal sync");
    chk_hper_line: assert property (act && hs_rise && line_cnt == mline[CW-1:0]
        |=> cur_h_per == $past(hcnt))
        else $error("horizontal period not taken on chosen line");
    chk_vper_commit: assert property (commit |=> res.v_per == $past(line_cnt))
        else $error("vertical period not committed");
    chk_res_hold: assert property (!commit |=> $stable(res) && $stable(r_phase))
        else $error("results changed outside a commit");
    chk_hwd_flag: assert property (act && hcnt > wd_thr[CW-1:0] |=> status[ST_HWD])
        else $error("horizontal watchdog missed");
    chk_vwd_flag: assert property (act && line_cnt > wd_thr[DATA_W-1:CW]
        |=> status[ST_VWD])
        else $error("vertical watchdog missed");
    chk_field_adc: assert property (!adc_path |=> !field_odd)
        else $error("field flag set outside converter path");
    chk_read_once: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data outside read slot");

    cov_commit: cover property (commit ##[1:1000] commit);
    cov_hchg: cover property (st_set[ST_HCHG]);
    cov_odd: cover property (vs_rise && adc_path ##1 field_odd);
    cov_hwd: cover property (st_set[ST_HWD] && st_clr[ST_HWD]);
endmodule
`default_nettype wire

/* common/inf_pkg.sv */
// Constants, register map and carrier types of the input format monitor.
// Assumes one core clock; every other rate arrives as a one-cycle enable.
package inf_pkg;
    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CW = 16;
    localparam int PIX_W = 8;
    localparam int MCLK_DIV = 4;
    localparam int DIV_W = 2;
    localparam int DLY_DEPTH = 32;
    localparam int DLY_W = 5;
    localparam int FSEL_W = 3;
    localparam int FLD_N = 8;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] A_HDLY = 8'h04;
    localparam logic [ADDR_W-1:0] A_MLINE = 8'h08;
    localparam logic [ADDR_W-1:0] A_CHG = 8'h0c;
    localparam logic [ADDR_W-1:0] A_WDOG = 8'h10;
    localparam logic [ADDR_W-1:0] A_FWIN = 8'h14;
    localparam logic [ADDR_W-1:0] A_STAT = 8'h18;
    localparam logic [ADDR_W-1:0] A_HRES = 8'h1c;
    localparam logic [ADDR_W-1:0] A_VRES = 8'h20;
    localparam logic [ADDR_W-1:0] A_ACTH = 8'h24;
    localparam logic [ADDR_W-1:0] A_ACTV = 8'h28;
    localparam logic [ADDR_W-1:0] A_PHASE = 8'h2c;
    localparam logic [ADDR_W-1:0] A_BNDH = 8'h30;
    localparam logic [ADDR_W-1:0] A_BNDV = 8'h34;
    localparam logic [ADDR_W-1:0] A_BAL = 8'h38;
    // ----------------------------------------
    // Fields and reset values
    // ----------------------------------------
    localparam int CTRL_RUN = 0;
    localparam int CTRL_URST = 1;
    localparam int CTRL_CSEL = 2;
    localparam int CTRL_SWAP = 3;
    localparam int CTRL_DLY = 4;
    localparam int ST_HCHG = 0;
    localparam int ST_VCHG = 1;
    localparam int ST_HWD = 2;
    localparam int ST_VWD = 3;
    localparam int ST_N = 4;
    localparam int RD_ODD = 4;
    localparam int RD_ARMED = 5;
    localparam int FWIN_S = 0;
    localparam int FWIN_E = 4;
    localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0002;
    localparam logic [DATA_W-1:0] MLINE_RST = 32'h0000_0010;
    localparam logic [DATA_W-1:0] CHG_RST = 32'h0004_0004;
    localparam logic [DATA_W-1:0] WDOG_RST = 32'h0800_ffff;
    localparam logic [DATA_W-1:0] FWIN_RST = 32'h0000_0030;
    localparam logic [DATA_W-1:0] ACT_RST = 32'hffff_0000;
    localparam logic [PIX_W-1:0] BND_LEVEL = 8'h20;
    localparam logic [CW-1:0] FLD_PTS [FLD_N] = '{16'h0000, 16'h0004, 16'h0008,
        16'h0010, 16'h0020, 16'h0040, 16'h0080, 16'h0100};
    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [CW-1:0] h_per;
        logic [CW-1:0] h_wid;
        logic [CW-1:0] v_per;
        logic [CW-1:0] v_wid;
    } inf_timing_t;
endpackage

/* hw/inf_clk_div.sv */
// Measurement clock enable: crystal tick or synthesized tick divided down.
// Assumes both ticks are one-cycle pulses in the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module inf_clk_div
    import inf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic xtal_tick,
    input wire logic synth_tick,
    input wire logic sel_synth,
    output logic meas_en
);
    logic [DIV_W-1:0] cnt;
    logic synth_en;

    assign synth_en = synth_tick && (cnt == DIV_W'(MCLK_DIV - 1));

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            cnt <= '0;
        else if (synth_tick)
            cnt <= cnt + 1'b1;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            meas_en <= 1'b0;
        else
            meas_en <= sel_synth ? synth_en : xtal_tick;
    end
endmodule
`default_nettype wire

/* hw/inf_hs_delay.sv */
// Programmable delay of the horizontal sync in input clock ticks.
// Assumes pix_en marks one input clock and hs_in is synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module inf_hs_delay
    import inf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic pix_en,
    input wire logic hs_in,
    input wire logic dly_on,
    input wire logic [DLY_W-1:0] dly,
    output logic hs_out
);
    logic [DLY_DEPTH-1:0] taps;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            taps <= '0;
        else if (pix_en)
            taps <= {taps[DLY_DEPTH-2:0], hs_in};
    end

    // Pass-through keeps one register; the tap path lags it by dly plus one input clock.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            hs_out <= 1'b0;
        else
            hs_out <= dly_on ? taps[dly] : hs_in;
    end
endmodule
`default_nettype wire

/* dv/inf_video_src.sv */
// Video source model: sync pins and pixel data for the input format monitor.
// Assumes the bench sets the line and frame shape; all timing is in core clocks.
`timescale 1ns/1ps
`default_nettype none
module inf_video_src
    import inf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [CW-1:0] line_len,
    input wire logic [CW-1:0] hs_wid,
    input wire logic [CW-1:0] frame_lines,
    input wire logic [CW-1:0] vs_wid,
    output logic hsync_pin,
    output logic vsync_pin,
    output logic pix_en,
    output logic [PIX_W-1:0] pix_data
);
    // ----------------------------------------
    // Raster
    // ----------------------------------------
    // Vertical sync moves at mid-line so it never meets a rising horizontal edge.
    logic [CW-1:0] hcnt;
    logic [CW-1:0] line;
    assign hsync_pin = hcnt < hs_wid;
    assign pix_en = 1'b1;
    assign pix_data = hcnt[7:0] ^ line[7:0];
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            hcnt <= '0;
            line <= '0;
            vsync_pin <= 1'b0;
        end
        else
        begin
            hcnt <= (hcnt >= line_len - 16'h1) ? '0 : hcnt + 16'h1;
            if (hcnt >= line_len - 16'h1)
                line <= (line >= frame_lines - 16'h1) ? '0 : line + 16'h1;
            if (hcnt == (line_len >> 1))
                vsync_pin <= line < vs_wid;
        end
    end
endmodule
`default_nettype wire

/* dv/input_format_measurement_test.sv */
// Bench of the input format monitor driven by a random video source.
// Assumes the source model owns the sync pins and pixel data.
`timescale 1ns/1ps
`default_nettype none
module input_format_measurement_test
    import inf_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic adc_path = 1'b0;
    logic xtal_tick = 1'b1;
    logic synth_tick = 1'b1;
    logic [DATA_W-1:0] reg_rdata;
    logic hsync_pin, vsync_pin, pix_en, field_odd, unit_active;
    logic [PIX_W-1:0] pix_data;
    logic [CW-1:0] lp = 16'h40, hw = 16'h8, fl = 16'h14, vw = 16'h2;
    logic [31:0] seed = 32'he81f;
    logic [31:0] d, prev_h;
    logic [39:0] rst_tab [7] = '{{A_CTRL, CTRL_RST}, {A_MLINE, MLINE_RST}, {A_CHG, CHG_RST},
        {A_WDOG, WDOG_RST}, {A_FWIN, FWIN_RST}, {A_ACTH, ACT_RST}, {8'h3c, 32'h0}};
    int n_fail = 0, n_compared = 0, cyc = 0, sh, fx;
    always #4 core_clk = ~core_clk;
    inf_monitor inf_monitor_inst (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .hsync_pin, .vsync_pin, .adc_path, .xtal_tick, .synth_tick, .pix_en,
        .pix_data, .field_odd, .unit_active);
    inf_video_src inf_video_src_inst (.core_clk, .rst, .line_len(lp), .hs_wid(hw),
        .frame_lines(fl), .vs_wid(vw), .hsync_pin, .vsync_pin, .pix_en, .pix_data);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // Balance result over a whole frame: the smallest pixel is zero, the largest is searched.
    function automatic logic [31:0] bal_exp(input int n);
        logic [7:0] m;
        m = '0;
        for (int h = 0; h < n; h++)
            for (int l = 0; l < int'(fl); l++)
                if (8'(h ^ l) > m)
                    m = 8'(h ^ l);
        return {16'h0, m, 8'h0};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // A commit needs one arming edge and one full frame, so three frames cover any phase.
    task automatic frames(input int n);
        repeat (n * int'(lp) * int'(fl) + 50) @(posedge core_clk);
    endtask
    task automatic end_sim;
        $display("Mismatches %0d of %0d compares", n_fail, n_compared);
        if (n_fail == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            n_fail++;
            end_sim();
        end
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        #1 check({31'h0, unit_active}, 32'h0);
        foreach (rst_tab[i])
        begin
            rd(rst_tab[i][39:32]);
            check(d, rst_tab[i][31:0]);
        end
        for (int i = 0; i < 3; i++)
        begin
            wr(A_CTRL, 32'h0);
            if (i > 0)
            begin
                rd(A_HRES);
                check(d, prev_h);
            end
            seed = xs(seed);
            lp = 16'h30 + {9'h0, seed[4:0], 2'b00};
            hw = 16'h4 + {11'h0, seed[7:5], 2'b00};
            vw = 16'h1 + {14'h0, seed[9:8]};
            sh = (i == 1) ? 2 : 0;
            adc_path <= (i == 2);
            // Delay kept below half a line so delayed sync never meets the vertical edge.
            wr(A_HDLY, {28'h0, seed[13:10]});
            wr(A_CTRL, 32'h1 | ((i == 1) ? 32'h4 : 32'h0) | ((i == 2) ? 32'h18 : 32'h0));
            check({31'h0, unit_active}, 32'h1);
            frames(3);
            prev_h = {hw >> sh, lp >> sh};
            rd(A_HRES);
            check(d, prev_h);
            rd(A_VRES);
            check(d, {vw, fl});
            if (i == 2)
            begin
                fx = int'(lp >> 1) - int'(seed[13:10]);
                check({31'h0, field_odd}, {31'h0, fx > 16});
            end
            if (i == 0)
            begin
                rd(A_STAT);
                check({28'h0, d[3:0]}, 32'h0);
            end
        end
        adc_path <= 1'b0;
        wr(A_CTRL, 32'h1);
        frames(2);
        wr(A_STAT, 32'hf);
        lp = lp + 16'h8;
        wr(A_WDOG, {fl - 16'h2, lp - 16'h2});
        frames(2);
        rd(A_STAT);
        check({28'h0, d[3:0]}, 32'hd);
        check({31'h0, field_odd}, 32'h0);
        wr(A_WDOG, WDOG_RST);
        wr(A_STAT, 32'hf);
        rd(A_STAT);
        check({28'h0, d[3:0]}, 32'h0);
        wr(A_CTRL, 32'h3);
        check({31'h0, unit_active}, 32'h0);
        rd(A_HRES);
        check(d, {hw, lp});
        rd(A_BAL);
        check(d, bal_exp(int'(lp)));
        end_sim();
    end
endmodule
`default_nettype wire
